// ---- core/objctl_pkg.sv ----
// Constants, types and register map for the switchgear object controller.
// Assumes one 50 MHz system clock and a plain word-wide register port.
//
// Behaviour
// - Count failed open and close requests, 32-bit.
// - Clear-statistics command zeroes all request counters.
// - Clear-statistics control returns to idle by itself.
// - Breaker types: control, ready, sync; withdrawable adds cart.
// - Earth switch: position only, never commands.
// - Main disconnector: position and control, no checks.
// - Open and close are pulses on separate outputs.
// - Both positions after traverse time means bad.
// - No position after traverse time means intermediate.
// - Each command pulse limited by its own maximum.
// - Pulse ends at once when position reached.
// - Termination timeout raises error, ends the operation.
// - Final trip gives pulse of configurable length.
// - Final trip length zero holds output until the next close starts.
// - Final trip only when no reclose is expected.
// - Local, remote, application each have request lines.
// - Sync check enabled blocks close without permission.
// - Ready check enabled blocks close on wrong level.
// - Count successful requests, cleared by clear-statistics.
package objctl_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int STEP_MS = 20;
  localparam int TICK_CYC = CLK_HZ / 1000 * STEP_MS;
  localparam int TICK_W = 20;
  localparam int SET_W = 16;
  localparam int CNT_W = 32;
  localparam int ADDR_W = 8;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] A_TRAV = 8'h04;
  localparam logic [ADDR_W-1:0] A_CLOSE_LEN = 8'h08;
  localparam logic [ADDR_W-1:0] A_OPEN_LEN = 8'h0c;
  localparam logic [ADDR_W-1:0] A_TERM = 8'h10;
  localparam logic [ADDR_W-1:0] A_FTRIP = 8'h14;
  localparam logic [ADDR_W-1:0] A_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] A_CNT0 = 8'h1c;

  // Control word fields
  localparam int CTL_TYPE_LSB = 0;
  localparam int CTL_SYNC_BIT = 2;
  localparam int CTL_RDY_LSB = 3;
  localparam int CTL_CLR_BIT = 8;

  // Reset values of the timing settings, in 20 ms steps
  localparam logic [SET_W-1:0] TRAV_RST = 16'h000a;
  localparam logic [SET_W-1:0] PULSE_RST = 16'h000a;
  localparam logic [SET_W-1:0] TERM_RST = 16'h01f4;
  localparam logic [SET_W-1:0] FTRIP_RST = 16'h000a;

  typedef enum logic [1:0] {
    TYPE_WD_CB = 2'b00,
    TYPE_CB = 2'b01,
    main_disconnector_type = 2'b10,
    TYPE_GND_DISC = 2'b11
  } obj_type_t;

  typedef enum logic [1:0] {
    RDY_OFF = 2'b00,
    RDY_HIGH = 2'b01,
    RDY_LOW = 2'b10,
    RDY_RSVD = 2'b11
  } rdy_mode_t;

  typedef enum logic [1:0] {
    POS_MID = 2'b00,
    POS_OPEN = 2'b01,
    POS_CLOSED = 2'b10,
    POS_BAD = 2'b11
  } pos_t;

  typedef enum logic [2:0] {
    CART_MID = 3'b000,
    CART_OUT = 3'b001,
    CART_IN = 3'b010,
    CART_BAD = 3'b011,
    CART_NA = 3'b100
  } cart_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_PULSE = 2'b01,
    S_WAIT = 2'b10
  } op_state_t;

  // Field status inputs from the switchgear
  typedef struct packed {
    logic pos_open;
    logic pos_closed;
    logic cart_inserted_input;
    logic cart_withdrawn_input;
    logic obj_ready;
    logic sync_ok;
    logic reclose_pending;
  } field_in_t;

  // Request lines, one per source and direction
  typedef struct packed {
    logic loc_open;
    logic loc_close;
    logic rem_open;
    logic rem_close;
    logic app_open;
    logic app_close;
  } req_t;
endpackage : objctl_pkg

// ---- core/switchgear_object_control.sv ----
// Open/close control and position monitoring of one switchgear object.
// Field and request inputs are asynchronous levels; registers on mclk.
`timescale 1ns/1ps
`default_nettype none
module switchgear_object_control
  import objctl_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic mclk, // System clock
  input wire logic arst_n, // Async reset
  input wire field_in_t field, // Field status pins
  input wire req_t req, // Request lines
  input wire logic [ADDR_W-1:0] addr, // Register byte address
  input wire logic [CNT_W-1:0] wdata, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  output logic [CNT_W-1:0] rdata, // Read data, cycle after rd_en
  output logic open_cmd, // Open relay pulse
  output logic close_cmd, // Close relay pulse
  output logic final_trip, // Final trip output
  output logic timeout_evt // Termination timeout event
);

  localparam int NS = $bits(field_in_t) + $bits(req_t);
  ////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [NS-1:0] raw;
  logic [NS-1:0] sy;
  field_in_t fs;
  req_t rs;
  assign raw = {field, req};
  genvar gi;
  for (gi = 0; gi < NS; gi++) begin : g_sync
    logic m_q;
    logic s_q;
    // Two stages; only the second is read
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        m_q <= 1'b0;
        s_q <= 1'b0;
      end else begin
        m_q <= raw[gi];
        s_q <= m_q;
      end
    end
    assign sy[gi] = s_q;
  end
  assign {fs, rs} = sy;
  ////////////////////////////////////////////////////////////////////
  // Step tick
  logic [TICK_W-1:0] tick_cnt_q;
  logic tick_q;
  // One pulse per setting step, so every timer is exact to one step
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == TICK_W'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Settings registers
  obj_type_t type_q;
  logic sync_use_q;
  rdy_mode_t rdy_q;
  logic [SET_W-1:0] trav_set_q;
  logic [SET_W-1:0] close_len_q;
  logic [SET_W-1:0] open_len_q;
  logic [SET_W-1:0] term_set_q;
  logic [SET_W-1:0] ftrip_set_q;
  logic clr;
  // Clear is a strobe taken from the write; nothing stores it
  assign clr = wr_en && addr == A_CTRL && wdata[CTL_CLR_BIT];
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      type_q <= TYPE_CB;
      sync_use_q <= 1'b0;
      rdy_q <= RDY_OFF;
      trav_set_q <= TRAV_RST;
      close_len_q <= PULSE_RST;
      open_len_q <= PULSE_RST;
      term_set_q <= TERM_RST;
      ftrip_set_q <= FTRIP_RST;
    end else if (wr_en) begin
      case (addr)
        A_CTRL: begin
          type_q <= obj_type_t'(wdata[CTL_TYPE_LSB +: 2]);
          sync_use_q <= wdata[CTL_SYNC_BIT];
          rdy_q <= rdy_mode_t'(wdata[CTL_RDY_LSB +: 2]);
        end
        A_TRAV: trav_set_q <= wdata[SET_W-1:0];
        A_CLOSE_LEN: close_len_q <= wdata[SET_W-1:0];
        A_OPEN_LEN: open_len_q <= wdata[SET_W-1:0];
        A_TERM: term_set_q <= wdata[SET_W-1:0];
        A_FTRIP: ftrip_set_q <= wdata[SET_W-1:0];
        default: ;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Position decode
  pos_t pos_q;
  cart_t cart_q;
  logic [SET_W-1:0] trav_cnt_q;
  logic one_pos;
  assign one_pos = fs.pos_open ^ fs.pos_closed;
  // Invalid combinations are tolerated while the contacts travel
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pos_q <= POS_MID;
      trav_cnt_q <= '0;
    end else if (one_pos) begin
      pos_q <= fs.pos_open ? POS_OPEN : POS_CLOSED;
      trav_cnt_q <= '0;
    end else if (trav_cnt_q >= trav_set_q) begin
      pos_q <= fs.pos_open ? POS_BAD : POS_MID;
    end else if (tick_q) begin
      trav_cnt_q <= trav_cnt_q + 1'b1;
    end
  end

  // Cart is monitored on the withdrawable breaker only
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cart_q <= CART_NA;
    end else if (type_q != TYPE_WD_CB) begin
      cart_q <= CART_NA;
    end else begin
      case ({fs.cart_inserted_input, fs.cart_withdrawn_input})
        2'b10: cart_q <= CART_IN;
        2'b01: cart_q <= CART_OUT;
        2'b11: cart_q <= CART_BAD;
        default: cart_q <= CART_MID;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Request decode and close conditions
  logic open_lvl;
  logic close_lvl;
  logic open_prev_q;
  logic close_prev_q;
  logic open_req;
  logic close_req;
  logic is_cb;
  logic is_gnd;
  logic blk_close;
  // Any source may request; sources stay separate lines
  assign open_lvl = rs.loc_open | rs.rem_open | rs.app_open;
  assign close_lvl = rs.loc_close | rs.rem_close | rs.app_close;
  assign open_req = open_lvl & ~open_prev_q;
  assign close_req = close_lvl & ~close_prev_q;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      open_prev_q <= 1'b0;
      close_prev_q <= 1'b0;
    end else begin
      open_prev_q <= open_lvl;
      close_prev_q <= close_lvl;
    end
  end
  assign is_cb = type_q == TYPE_WD_CB || type_q == TYPE_CB;
  assign is_gnd = type_q == TYPE_GND_DISC;
  // Checks apply to breaker types only
  assign blk_close = is_gnd
      | (is_cb & sync_use_q & ~fs.sync_ok)
      | (is_cb & rdy_q == RDY_HIGH & ~fs.obj_ready)
      | (is_cb & rdy_q == RDY_LOW & fs.obj_ready);
  ////////////////////////////////////////////////////////////////////
  // Operation sequencer
  op_state_t state_q;
  logic tgt_close_q;
  logic [SET_W-1:0] pulse_cnt_q;
  logic [SET_W-1:0] term_cnt_q;
  logic idle;
  logic active;
  logic reached;
  logic term_exp;
  logic pulse_exp;
  logic start_open;
  logic start_close;
  logic [3:0] inc;
  assign idle = state_q == S_IDLE;
  assign active = ~idle;
  assign reached = active & (tgt_close_q ? pos_q == POS_CLOSED : pos_q == POS_OPEN);
  assign term_exp = active & ~reached & term_cnt_q >= term_set_q;
  assign pulse_exp = state_q == S_PULSE
      & pulse_cnt_q >= (tgt_close_q ? close_len_q : open_len_q);
  // Open wins when both directions arrive together
  assign start_open = idle & open_req & ~is_gnd;
  assign start_close = idle & ~open_req & close_req & ~blk_close;
  // Order: open ok, close ok, open failed, close failed
  assign inc[0] = reached & ~tgt_close_q;
  assign inc[1] = reached & tgt_close_q;
  assign inc[2] = (idle & open_req & is_gnd) | (term_exp & ~tgt_close_q);
  assign inc[3] = (idle & ~open_req & close_req & blk_close)
      | (term_exp & tgt_close_q);
  // A request arriving mid-operation is ignored, not counted
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= S_IDLE;
      tgt_close_q <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (start_open || start_close) begin
            state_q <= S_PULSE;
            tgt_close_q <= start_close;
          end
        end
        S_PULSE: begin
          if (reached || term_exp) begin
            state_q <= S_IDLE;
          end else if (pulse_exp) begin
            state_q <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (reached || term_exp) begin
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Pulse and termination timers, restarted with each operation
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pulse_cnt_q <= '0;
      term_cnt_q <= '0;
    end else if (idle) begin
      pulse_cnt_q <= '0;
      term_cnt_q <= '0;
    end else if (tick_q) begin
      if (state_q == S_PULSE) begin
        pulse_cnt_q <= pulse_cnt_q + 1'b1;
      end
      term_cnt_q <= term_cnt_q + 1'b1;
    end
  end

  // Relay pulses; dropped on arrival, pulse limit or timeout
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      open_cmd <= 1'b0;
      close_cmd <= 1'b0;
    end else if (start_open) begin
      open_cmd <= 1'b1;
    end else if (start_close) begin
      close_cmd <= 1'b1;
    end else if (reached || term_exp || pulse_exp || idle) begin
      open_cmd <= 1'b0;
      close_cmd <= 1'b0;
    end
  end

  // Error event lasts one cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      timeout_evt <= 1'b0;
    end else begin
      timeout_evt <= term_exp;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Final trip
  logic [SET_W-1:0] ft_cnt_q;
  // Zero length holds until the next close starts
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      final_trip <= 1'b0;
      ft_cnt_q <= '0;
    end else if (inc[0] && !fs.reclose_pending) begin
      final_trip <= 1'b1;
      ft_cnt_q <= '0;
    end else if (start_close) begin
      final_trip <= 1'b0;
    end else if (final_trip && ftrip_set_q != '0) begin
      if (ft_cnt_q >= ftrip_set_q) begin
        final_trip <= 1'b0;
      end else if (tick_q) begin
        ft_cnt_q <= ft_cnt_q + 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Request statistics
  logic [CNT_W-1:0] stat_q [4];
  for (gi = 0; gi < 4; gi++) begin : g_stat
    // Increment in the clear cycle survives as a count of one
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        stat_q[gi] <= '0;
      end else if (clr) begin
        stat_q[gi] <= {{(CNT_W-1){1'b0}}, inc[gi]};
      end else if (inc[gi]) begin
        stat_q[gi] <= stat_q[gi] + 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Read port
  logic [CNT_W-1:0] status_w;
  // Ten status bits, zero padded to the full word
  assign status_w = {22'h000000, active, final_trip, close_cmd, open_cmd,
                     cart_q, pos_q, tgt_close_q};
  // Data stands for one cycle only, zero otherwise
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= '0;
    end else if (rd_en) begin
      case (addr)
        A_CTRL: rdata <= {23'h000000, 1'b0, 3'h0, rdy_q, sync_use_q, type_q};
        A_TRAV: rdata <= {16'h0000, trav_set_q};
        A_CLOSE_LEN: rdata <= {16'h0000, close_len_q};
        A_OPEN_LEN: rdata <= {16'h0000, open_len_q};
        A_TERM: rdata <= {16'h0000, term_set_q};
        A_FTRIP: rdata <= {16'h0000, ftrip_set_q};
        A_STATUS: rdata <= status_w;
        A_CNT0: rdata <= stat_q[0];
        A_CNT0 + 8'h04: rdata <= stat_q[1];
        A_CNT0 + 8'h08: rdata <= stat_q[2];
        A_CNT0 + 8'h0c: rdata <= stat_q[3];
        default: rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

endmodule : switchgear_object_control
`default_nettype wire

// ---- sim/objctl_asserts.sv ----
// Concurrent checks on the object controller's top ports.
// Assumes a bind from the bench top; pulse settings stay at or below defaults.
`timescale 1ns/1ps
`default_nettype none
module objctl_asserts
  import objctl_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic mclk, // System clock
  input wire logic arst_n, // Async reset
  input wire field_in_t field, // Field status pins
  input wire req_t req, // Request lines
  input wire logic [ADDR_W-1:0] addr, // Register address
  input wire logic [CNT_W-1:0] wdata, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  input wire logic [CNT_W-1:0] rdata, // Read data
  input wire logic open_cmd, // Open relay pulse
  input wire logic close_cmd, // Close relay pulse
  input wire logic final_trip, // Final trip output
  input wire logic timeout_evt // Timeout event
);
  // Default maximum plus one early tick and sync slack
  localparam int PMAX = 11 * TICK_CYCLES + 4;
  logic [31:0] run_q;
  wire logic open_rq = req.loc_open | req.rem_open | req.app_open;
  wire logic close_rq = req.loc_close | req.rem_close | req.app_close;
  wire logic at_open = field.pos_open & ~field.pos_closed;
  wire logic at_closed = field.pos_closed & ~field.pos_open;

  ////////////////////////////////////////////////////////////
  // Length of the command pulse now standing
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      run_q <= '0;
    end else begin
      run_q <= (open_cmd | close_cmd) ? run_q + 32'h1 : '0;
    end
  end

  default clocking dc @(posedge mclk); endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////
  cmd_excl_a: assert property (!(open_cmd && close_cmd))
    else $error("open and close commands both high");
  pulse_max_a: assert property (run_q <= PMAX)
    else $error("command pulse exceeds its maximum");
  open_end_a: assert property ((open_cmd && at_open) [*6] |=> !open_cmd)
    else $error("open pulse kept after object opened");
  close_end_a: assert property ((close_cmd && at_closed) [*6] |=> !close_cmd)
    else $error("close pulse kept after object closed");
  open_cause_a: assert property ($rose(open_cmd) |-> $past(open_rq, 2) || $past(open_rq, 3))
    else $error("open pulse without a request");
  close_cause_a: assert property ($rose(close_cmd) |-> $past(close_rq, 2) || $past(close_rq, 3))
    else $error("close pulse without a request");
  timeout_end_a: assert property (timeout_evt |=> !timeout_evt && !open_cmd && !close_cmd)
    else $error("operation not ended at timeout");
  ftrip_open_a: assert property ($rose(final_trip) |-> $fell(open_cmd))
    else $error("final trip without an ended open");
  ftrip_recl_a: assert property ($rose(final_trip) |-> !field.reclose_pending)
    else $error("final trip while reclose expected");
  rdata_idle_a: assert property (!$past(rd_en) |-> rdata == '0)
    else $error("read data outside the read slot");

  // Main scenarios reached
  cover property ($rose(final_trip));
  cover property (timeout_evt);
  cover property ($fell(close_cmd));
endmodule : objctl_asserts
`default_nettype wire

// ---- sim/breaker_model.sv ----
// Behavioural breaker on the field side: positions, cart, ready, sync.
// Assumes command pulses from the controller; the tb sets the slow/stuck modes.
`timescale 1ns/1ps
`default_nettype none
module breaker_model
  import objctl_pkg::*;
(
  input wire logic mclk, // System clock
  input wire logic arst_n, // Async reset
  input wire logic open_cmd, // Open relay
  input wire logic close_cmd, // Close relay
  input wire logic slow, // Long travel
  input wire logic stuck, // Jammed mid-travel
  input wire logic ready, // Spring charged
  input wire logic sync_ok, // Sync permission
  input wire logic recl, // Reclose expected
  output field_in_t field // Status pins
);
  logic closed_q;
  logic moving_q;
  logic [9:0] trav_q;

  ////////////////////////////////////////////////////////////
  // Travel completes once started, even if the pulse is cut short
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      closed_q <= 1'b1;
      moving_q <= 1'b0;
      trav_q <= '0;
    end else if (moving_q) begin
      if (!stuck) begin
        trav_q <= trav_q + 10'h1;
      end
      // Slow travel outlasts the cut pulse but stays inside the bench's timeout
      if (trav_q == (slow ? 10'd150 : 10'd20)) begin
        moving_q <= 1'b0;
        closed_q <= ~closed_q;
      end
    end else if ((open_cmd && closed_q) || (close_cmd && !closed_q)) begin
      moving_q <= 1'b1;
      trav_q <= '0;
    end
  end

  // Both positions low while travelling
  assign field.pos_open = !moving_q && !closed_q;
  assign field.pos_closed = !moving_q && closed_q;
  assign field.cart_inserted_input = 1'b1;
  assign field.cart_withdrawn_input = 1'b0;
  assign field.obj_ready = ready;
  assign field.sync_ok = sync_ok;
  assign field.reclose_pending = recl;
endmodule : breaker_model
`default_nettype wire

// ---- sim/switchgear_object_control_test.sv ----
// Self-checking bench for the object controller with a breaker model.
// Assumes a 10-cycle tick; expectations after the reset checks come from settings written here.
`timescale 1ns/1ps
`default_nettype none
module switchgear_object_control_test;
  import objctl_pkg::*;
  logic mclk, arst_n, wr_en, rd_en, slow, stuck, ready, sync_ok, recl, t_seen;
  logic [ADDR_W-1:0] addr;
  logic [CNT_W-1:0] wdata, rdata, d;
  logic open_cmd, close_cmd, final_trip, timeout_evt;
  logic [CNT_W-1:0] exp_cnt [4]; // Open ok, close ok, open fail, close fail
  field_in_t field;
  req_t req;
  int failures, cmp_count, cyc;

  switchgear_object_control #(.TICK_CYCLES(10)) switchgear_object_control_i (
    .mclk(mclk), .arst_n(arst_n), .field(field), .req(req), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .open_cmd(open_cmd),
    .close_cmd(close_cmd), .final_trip(final_trip), .timeout_evt(timeout_evt));
  breaker_model breaker_model_i (
    .mclk(mclk), .arst_n(arst_n), .open_cmd(open_cmd), .close_cmd(close_cmd),
    .slow(slow), .stuck(stuck), .ready(ready), .sync_ok(sync_ok), .recl(recl),
    .field(field));

  ////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("compares %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [CNT_W-1:0] seen, input logic [CNT_W-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [CNT_W-1:0] v);
    @(posedge mclk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask : wr
  // Read data is taken in the one cycle it stands
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge mclk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic rc(input logic [ADDR_W-1:0] a, input logic [CNT_W-1:0] e);
    rd(a);
    chk(d, e);
  endtask : rc
  // Request held long enough to pass the input synchronisers
  task automatic do_req(input int b);
    @(posedge mclk);
    req <= req_t'(6'h01 << b);
    repeat (8) @(posedge mclk);
    req <= '0;
  endtask : do_req
  task automatic wait_idle;
    for (int i = 0; i < 400; i++) begin
      rd(A_STATUS);
      if (d[9] === 1'b0) break;
    end
    chk(32'(d[9]), 32'h0);
  endtask : wait_idle
  task automatic chk_cnt;
    for (int i = 0; i < 4; i++) begin
      rc(A_CNT0 + 8'(4 * i), exp_cnt[i]);
    end
  endtask : chk_cnt
  task automatic step(input int b, input int k);
    do_req(b);
    wait_idle();
    exp_cnt[k] = exp_cnt[k] + 32'h1;
    chk_cnt();
  endtask : step

  ////////////////////////////////////////////////////////////
  // Clock at 50 MHz
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      test_done();
    end
  end

  initial begin
    arst_n = 1'b0;
    {wr_en, rd_en, slow, stuck, ready, sync_ok, recl} = '0;
    addr = '0;
    wdata = '0;
    req = '0;
    exp_cnt = '{default: '0};
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    rc(A_CTRL, 32'h1);
    rc(A_TRAV, 32'ha);
    rc(A_CLOSE_LEN, 32'ha);
    rc(A_OPEN_LEN, 32'ha);
    rc(A_TERM, 32'h1f4);
    rc(A_FTRIP, 32'ha);
    rc(8'h40, 32'h0);
    repeat (120) @(posedge mclk);
    rd(A_STATUS);
    chk(32'(d[5:1]), 32'h12);
    $display("reset test ended");
    wr(A_TERM, 32'd30);
    wr(A_FTRIP, 32'd3);
    // Local open, then a short final trip pulse
    do_req(5);
    wait_idle();
    chk(32'(final_trip), 32'h1);
    exp_cnt[0] = 32'h1;
    repeat (50) @(posedge mclk);
    chk(32'(final_trip), 32'h0);
    $display("open test ended");
    // Each close condition blocks once, then a clean close
    for (int i = 0; i < 3; i++) begin
      ready <= (i == 2);
      wr(A_CTRL, (i == 0) ? 32'h05 : (i == 1) ? 32'h08 : 32'h11);
      step(4 - 2 * i, 3);
    end
    wr(A_CTRL, 32'h05);
    sync_ok <= 1'b1;
    step(0, 1);
    $display("close checks test ended");
    // Earth switch refuses, main disconnector skips checks
    wr(A_CTRL, 32'h3);
    step(3, 2);
    step(4, 3);
    wr(A_CTRL, 32'h6);
    sync_ok <= 1'b0;
    recl <= 1'b1;
    step(1, 0);
    chk(32'(final_trip), 32'h0);
    step(4, 1);
    step(1, 0);
    wr(A_CTRL, 32'h0);
    rd(A_STATUS);
    chk(32'(d[5:3]), 32'h2);
    $display("type test ended");
    // Slow close: pulse cut at its maximum, operation still completes
    wr(A_CTRL, 32'h1);
    wr(A_CLOSE_LEN, 32'd2);
    slow <= 1'b1;
    do_req(4);
    repeat (40) @(posedge mclk);
    chk(32'(close_cmd), 32'h0);
    rd(A_STATUS);
    chk(32'(d[9]), 32'h1);
    wait_idle();
    exp_cnt[1] = exp_cnt[1] + 32'h1;
    slow <= 1'b0;
    chk_cnt();
    $display("pulse limit test ended");
    // Jammed open: intermediate status and termination timeout
    stuck <= 1'b1;
    t_seen = 1'b0;
    do_req(5);
    #1 chk(32'(open_cmd), 32'h1);
    for (int i = 0; i < 600 && !t_seen; i++) begin
      @(posedge mclk);
      #1 t_seen = (timeout_evt === 1'b1);
    end
    chk(32'(t_seen), 32'h1);
    rd(A_STATUS);
    chk(32'(d[2:1]), 32'h0);
    exp_cnt[2] = exp_cnt[2] + 32'h1;
    chk_cnt();
    stuck <= 1'b0;
    repeat (60) @(posedge mclk);
    recl <= 1'b0;
    $display("timeout test ended");
    // Clear strobe zeroes counters and reads back idle
    wr(A_CTRL, 32'h101);
    exp_cnt = '{default: '0};
    chk_cnt();
    rc(A_CTRL, 32'h1);
    $display("clear test ended");
    // Zero length holds final trip until the next close
    wr(A_FTRIP, 32'h0);
    step(4, 1);
    step(5, 0);
    repeat (100) @(posedge mclk);
    chk(32'(final_trip), 32'h1);
    step(2, 1);
    chk(32'(final_trip), 32'h0);
    $display("final trip hold test ended");
    test_done();
  end
endmodule : switchgear_object_control_test

bind switchgear_object_control objctl_asserts #(.TICK_CYCLES(TICK_CYCLES)) objctl_asserts_i (
  .mclk(mclk), .arst_n(arst_n), .field(field), .req(req), .addr(addr), .wdata(wdata),
  .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .open_cmd(open_cmd), .close_cmd(close_cmd),
  .final_trip(final_trip), .timeout_evt(timeout_evt));
`default_nettype wire
